// File: core/uvol_pkg.sv
// Package: register offsets, field positions and reset values shared by
// the undervoltage / open-load fault logic and its register slave.
// Assumes a 32-bit AXI4-Lite register bus and four output channels.
package uvol_pkg;
	// Number of output channels
	localparam int NumOut = 4;
	// Register byte offsets
	localparam logic [7:0] CtrlOffset = 8'h00;
	localparam logic [7:0] ConfigOffset = 8'h04;
	localparam logic [7:0] StatusOffset = 8'h08;
	localparam logic [7:0] SenseOffset = 8'h0c;
	// Config field positions
	localparam int OlOffLsb = 0;
	localparam int UvOffBit = 4;
	// Status field positions
	localparam int UvFlagBit = 0;
	localparam int OlFlagLsb = 4;
	localparam int OutStateLsb = 8;
	localparam int FaultPinBit = 12;
	// Sense field positions
	localparam int BattLowBit = 0;
	localparam int BattPorBit = 1;
	localparam int BattDeadBit = 2;
	localparam int BattGoneBit = 3;
	localparam int GateOffLsb = 4;
	localparam int OpenSenseLsb = 8;
	// Reset values
	localparam logic [31:0] ResetZero = 32'h0000_0000;
	// AXI response codes
	localparam logic [1:0] RespOkay = 2'h0;
	localparam logic [1:0] RespSlvErr = 2'h2;
endpackage

// File: core/axil_reg_slave.sv
// Minimal AXI4-Lite slave: accepts one write and one read at a time,
// hands single-cycle write and read strobes to the owner of the registers.
// Assumes the owner returns read data combinationally from rdAddr.
`timescale 1ns/1ps
module axil_reg_slave
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wrStb,
	output logic [7:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrOk,
	output logic rdStb,
	output logic [7:0] rdAddr,
	input wire logic [31:0] rdData,
	input wire logic rdOk
);
	// Held address and data of the pending write
	logic awHave_q;
	logic wHave_q;
	// Both halves present, no response outstanding
	wire wrGo = awHave_q && wHave_q && !s_axi_bvalid;
	wire rdGo = s_axi_arvalid && s_axi_arready;

	// Strobes and read address are combinational
	assign wrStb = wrGo;
	assign rdStb = rdGo;
	assign rdAddr = s_axi_araddr;

	// Write channel capture and response
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= uvol_pkg::RespOkay;
			wrAddr <= 8'h00;
			wrData <= 32'h0000_0000;
			wrStrb <= 4'h0;
		end
		else
		begin
			// Address accepted
			s_axi_awready <= !awHave_q && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHave_q <= 1'b1;
				wrAddr <= s_axi_awaddr;
			end
			// Data accepted
			s_axi_wready <= !wHave_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHave_q <= 1'b1;
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
			end
			// Response issued the cycle after the strobe
			if (wrGo)
			begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrOk ? uvol_pkg::RespOkay
					: uvol_pkg::RespSlvErr;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one cycle to accept, answer the next
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= uvol_pkg::RespOkay;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rdGo)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdData;
				s_axi_rresp <= rdOk ? uvol_pkg::RespOkay
					: uvol_pkg::RespSlvErr;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// File: core/uv_ol_fault.sv
// Undervoltage and open-load fault logic of a four-channel high-side
// switch, with its control and status registers on AXI4-Lite.
// Assumes analog comparators deliver battery levels and per-output gate
// and open-load sense as synchronous levels; logic runs from logic supply.
`timescale 1ns/1ps
// Function
// - Battery low: output off, fault low, flag
// - Recovery, all commands off: fault pin high
// - Recovery with command on: stay off, toggle
// - Undervoltage flag held until status read
// - Protection off: flag only, outputs kept unless battery dead
// - Logic state kept during battery undervoltage
// - Pass-through works without battery supply
// - Open load checked only while commanded off
// - Open-load flag latched once gate off
// - Open-load flag cleared by read when gone
// - Configurable per-output open-load detection disable bits
// - Fault info returned and reset on read
// - Switch-off command releases latched fault
module uv_ol_fault
#(
	parameter int NumOut = uvol_pkg::NumOut
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NumOut-1:0] directIn,
	input wire logic batteryLow,
	input wire logic batteryPorLow,
	input wire logic batteryDead,
	input wire logic [NumOut-1:0] gateOff,
	input wire logic [NumOut-1:0] openSense,
	input wire logic chainIn,
	output logic chainOut,
	output logic [NumOut-1:0] outEnable,
	output logic fault_pin_n
);
	// Registers and status state
	logic [NumOut-1:0] serialOn_q;
	logic [NumOut-1:0] open_load_detect_off_q;
	logic undervoltage_protect_off_q;
	logic undervoltage_flag_q;
	logic [NumOut-1:0] open_load_flag_q;
	logic [NumOut-1:0] uvLatch_q;
	logic [NumOut-1:0] cmdPrev_q;
	// Bus strobes
	logic wrStb;
	logic rdStb;
	logic [7:0] wrAddr;
	logic [7:0] rdAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic [31:0] rdData;

	wire [NumOut-1:0] cmdOn = directIn | serialOn_q;
	wire [NumOut-1:0] cmdRise = cmdOn & ~cmdPrev_q;
	// Undervoltage applies when not disabled, or below the dead level
	wire uvActive = batteryLow && !undervoltage_protect_off_q;
	wire uvForceOff = uvActive || batteryDead;
	// Register decode
	wire wrCtrl = wrStb && wrAddr == uvol_pkg::CtrlOffset && wrStrb[0];
	wire wrCfg = wrStb && wrAddr == uvol_pkg::ConfigOffset && wrStrb[0];
	wire wrOk = wrAddr == uvol_pkg::CtrlOffset
		|| wrAddr == uvol_pkg::ConfigOffset;
	wire rdStatus = rdStb && rdAddr == uvol_pkg::StatusOffset;
	wire rdOk = rdAddr == uvol_pkg::CtrlOffset
		|| rdAddr == uvol_pkg::ConfigOffset
		|| rdAddr == uvol_pkg::StatusOffset
		|| rdAddr == uvol_pkg::SenseOffset;
	// open load seen only while off, gated
	wire [NumOut-1:0] olSeen = openSense & ~cmdOn & ~open_load_detect_off_q;
	// latch only once gate pulled off
	wire [NumOut-1:0] olSet = olSeen & gateOff;
	// output stays off while latched or under undervoltage
	wire [NumOut-1:0] outNext = cmdOn & ~uvLatch_q
		& ~{NumOut{uvForceOff}};
	// Fault pin: low on active undervoltage, latch or open load
	wire faultNext = !(uvActive || (|uvLatch_q) || (|olSet));
	// Read data selection
	wire [31:0] ctrlWord = {{(32-NumOut){1'b0}}, serialOn_q};
	wire [31:0] cfgWord = 32'(open_load_detect_off_q)
		| (32'(undervoltage_protect_off_q) << uvol_pkg::UvOffBit);
	wire [31:0] statusWord = (32'(undervoltage_flag_q) << uvol_pkg::UvFlagBit)
		| (32'(open_load_flag_q) << uvol_pkg::OlFlagLsb)
		| (32'(outEnable) << uvol_pkg::OutStateLsb)
		| (32'(fault_pin_n) << uvol_pkg::FaultPinBit);
	wire [31:0] senseWord = (32'(batteryLow) << uvol_pkg::BattLowBit)
		| (32'(batteryPorLow) << uvol_pkg::BattPorBit)
		| (32'(batteryDead) << uvol_pkg::BattDeadBit)
		| (32'(gateOff) << uvol_pkg::GateOffLsb)
		| (32'(openSense) << uvol_pkg::OpenSenseLsb);
	assign rdData = rdAddr == uvol_pkg::CtrlOffset ? ctrlWord
		: rdAddr == uvol_pkg::ConfigOffset ? cfgWord
		: rdAddr == uvol_pkg::StatusOffset ? statusWord
		: rdAddr == uvol_pkg::SenseOffset ? senseWord
		: uvol_pkg::ResetZero;

	// Bus slave
	axil_reg_slave u_slave
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wrStb(wrStb),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrOk(wrOk),
		.rdStb(rdStb),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.rdOk(rdOk)
	);

	// Software-written control and configuration
	// kept across undervoltage, reset only by reset_n
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			serialOn_q <= '0;
			open_load_detect_off_q <= '0;
			undervoltage_protect_off_q <= 1'b0;
		end
		else
		begin
			if (wrCtrl)
				serialOn_q <= wrData[NumOut-1:0];
			if (wrCfg)
			begin
				open_load_detect_off_q <= wrData[NumOut-1:0];
				undervoltage_protect_off_q <= wrData[uvol_pkg::UvOffBit];
			end
		end
	end

	// Undervoltage flag: set wins over read clear
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			undervoltage_flag_q <= 1'b0;
		// set under low battery whatever the disable bit
		else if (batteryLow)
			undervoltage_flag_q <= 1'b1;
		else if (rdStatus)
			undervoltage_flag_q <= 1'b0;
	end

	// Per-output latch, open-load flag and command history
	genvar i;
	generate
		for (i = 0; i < NumOut; i++)
		begin : g_out
			always_ff @(posedge sys_clk)
			begin
				if (!reset_n)
				begin
					uvLatch_q[i] <= 1'b0;
					cmdPrev_q[i] <= 1'b0;
					open_load_flag_q[i] <= 1'b0;
				end
				else
				begin
					cmdPrev_q[i] <= cmdOn[i];
					// latch when command on under active undervoltage
					// A dead battery forces off but never latches
					if (uvActive && cmdOn[i])
						uvLatch_q[i] <= 1'b1;
					else if (cmdRise[i])
						uvLatch_q[i] <= 1'b0;
					else if (!cmdOn[i])
						uvLatch_q[i] <= 1'b0;
					// set wins; cleared by read when gone
					if (olSet[i])
						open_load_flag_q[i] <= 1'b1;
					else if (rdStatus)
						open_load_flag_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Outputs, fault pin and chain pass-through, all registered
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			outEnable <= '0;
			fault_pin_n <= 1'b1;
			chainOut <= 1'b0;
		end
		else
		begin
			outEnable <= outNext;
			fault_pin_n <= faultNext;
			chainOut <= chainIn;
		end
	end

	// output off and pin low after active undervoltage
	a_uv_forces_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		uvActive |=> (outEnable == '0) && !fault_pin_n)
		else $error("undervoltage did not force outputs off");
	a_latch_holds_off: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(|uvLatch_q) |=> !fault_pin_n)
		else $error("latched undervoltage released fault pin");
	a_uv_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		batteryLow |=> undervoltage_flag_q)
		else $error("undervoltage flag not set");
	a_uv_flag_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		undervoltage_flag_q && !rdStatus |=> undervoltage_flag_q)
		else $error("undervoltage flag dropped without read");
	a_uv_off_keeps: assert property (@(posedge sys_clk) disable iff (!reset_n)
		undervoltage_protect_off_q && !batteryDead && !(|uvLatch_q)
		&& !(|olSet) |=> fault_pin_n && outEnable == $past(cmdOn))
		else $error("disabled protection changed outputs");
	// no open-load flag set on output 0 while on
	a_ol_only_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!open_load_flag_q[0] && cmdOn[0] |=> !open_load_flag_q[0])
		else $error("open load flagged while output on");
	// read clears flag once condition gone
	a_ol_read_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rdStatus && olSet == '0 |=> open_load_flag_q == '0)
		else $error("open load flag not cleared by read");
	a_chain_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
		##1 chainOut == $past(chainIn))
		else $error("chain pass-through broken");
	// fresh command clears output 0 latch if battery fine
	a_rise_release: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		cmdRise[0] && !uvForceOff |=> !uvLatch_q[0])
		else $error("switch-on did not release latch");
	// dead battery forces outputs off, pin untouched
	a_dead_forces_off: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		batteryDead && undervoltage_protect_off_q && !(|uvLatch_q)
		&& !(|olSet) |=> (outEnable == '0) && fault_pin_n)
		else $error("dead battery did not force outputs off");
endmodule

// File: tb/axil_host.sv
// Host model: AXI4-Lite master with one-word write and read tasks.
// Assumes the caller enters a task just after a rising clock edge.
`timescale 1ns/1ps
module axil_host
(
	input wire logic sys_clk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// Idle bus at time zero
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
	end

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge sys_clk);
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	// Read address, then wait for the data beat
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the undervoltage and open-load fault logic.
// Assumes the host model owns the register bus on the one 200 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, g) cmp(n, 34'(e), 34'(g))
module tb_top;
	localparam logic [7:0] Ctl = uvol_pkg::CtrlOffset;
	localparam logic [7:0] Cfg = uvol_pkg::ConfigOffset;
	localparam logic [7:0] Sta = uvol_pkg::StatusOffset;
	localparam logic [7:0] Sen = uvol_pkg::SenseOffset;
	localparam logic [1:0] Err = uvol_pkg::RespSlvErr;
	// Clock, reset and sense-side stimulus
	logic sys_clk, reset_n, batteryLow, batteryPorLow, batteryDead;
	logic chainIn, chainOut, fault_pin_n, prev;
	logic [3:0] directIn, gateOff, openSense, outEnable, c, o;
	// Register bus
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	// Expected bus results, oldest first
	logic [33:0] expQ[$];
	int numErrors = 0;
	int totalChecks = 0;
	int cycles = 0;

	uv_ol_fault uut
	(
		.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .directIn, .batteryLow,
		.batteryPorLow, .batteryDead, .gateOff, .openSense, .chainIn,
		.chainOut, .outEnable, .fault_pin_n
	);

	axil_host host
	(
		.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rvalid, .s_axi_rready
	);

	// Free-running 5 ns clock
	always #2.5 sys_clk = ~sys_clk;

	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			numErrors++;
			report_and_stop();
		end
	end

	// Bus monitor: each response is matched to the oldest note
	always @(posedge sys_clk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			`CHK("bresp", expQ.pop_front(), {s_axi_bresp, 32'h0});
		if (s_axi_rvalid && s_axi_rready)
			`CHK("rdata", expQ.pop_front(), {s_axi_rresp, s_axi_rdata});
	end

	task automatic cmp(string n, logic [33:0] e, logic [33:0] g);
		totalChecks++;
		if (g !== e)
		begin
			numErrors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic rdx(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
		expQ.push_back({r, d});
		host.rd(a);
	endtask

	task automatic wrx(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
		expQ.push_back({r, 32'h0});
		host.wr(a, d);
	endtask

	// Command from the direct pins or from the control register
	task automatic setCmd(int k, logic [3:0] v);
		if (k == 1)
			wrx(Ctl, {28'h0, v});
		else
			directIn <= v;
		tick(3);
	endtask

	task automatic pc(logic [3:0] oe, logic pin);
		`CHK("outEnable", oe, outEnable);
		`CHK("fault_pin_n", pin, fault_pin_n);
	endtask

	// Expected status word
	function automatic logic [31:0] st(logic uv, logic [3:0] ol, oe,
		logic pin);
		st = 32'h0;
		st[uvol_pkg::UvFlagBit] = uv;
		st[uvol_pkg::OlFlagLsb +: 4] = ol;
		st[uvol_pkg::OutStateLsb +: 4] = oe;
		st[uvol_pkg::FaultPinBit] = pin;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		{batteryLow, batteryPorLow, batteryDead, chainIn} = 4'h0;
		{directIn, openSense} = 8'h00;
		gateOff = 4'hf;
		void'($urandom(991));
		tick(20);
		reset_n <= 1'b1;
		tick(1);
		pc(4'h0, 1'b1);
		rdx(Cfg, 32'h0);
		rdx(Sta, st(1'b0, 4'h0, 4'h0, 1'b1));
		rdx(8'h10, 32'h0, Err);
		wrx(8'h10, 32'h1f, Err);
		rdx(Ctl, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 2; k++)
		begin
			setCmd(k, 4'h1);
			pc(4'h1, 1'b1);
			batteryLow <= 1'b1;
			tick(3);
			pc(4'h0, 1'b0);
			rdx(Sta, st(1'b1, 4'h0, 4'h0, 1'b0));
			batteryLow <= 1'b0;
			tick(3);
			pc(4'h0, 1'b0);
			rdx(Sta, st(1'b1, 4'h0, 4'h0, 1'b0));
			setCmd(k, 4'h0);
			pc(4'h0, 1'b1);
			setCmd(k, 4'h1);
			pc(4'h1, 1'b1);
			rdx(Sta, st(1'b0, 4'h0, 4'h1, 1'b1));
			setCmd(k, 4'h0);
		end
		batteryLow <= 1'b1;
		tick(3);
		batteryLow <= 1'b0;
		tick(3);
		pc(4'h0, 1'b1);
		rdx(Sta, st(1'b1, 4'h0, 4'h0, 1'b1));
		rdx(Sta, st(1'b0, 4'h0, 4'h0, 1'b1));
		$display("test undervoltage done");
		wrx(Cfg, 32'h10);
		setCmd(1, 4'h2);
		batteryLow <= 1'b1;
		tick(3);
		pc(4'h2, 1'b1);
		rdx(Sta, st(1'b1, 4'h0, 4'h2, 1'b1));
		rdx(Cfg, 32'h10);
		rdx(Ctl, 32'h2);
		batteryDead <= 1'b1;
		tick(3);
		pc(4'h0, 1'b1);
		{batteryLow, batteryDead} <= 2'h0;
		wrx(Cfg, 32'h0);
		setCmd(1, 4'h0);
		rdx(Sta, st(1'b1, 4'h0, 4'h0, 1'b1));
		$display("test protect off done");
		for (int i = 0; i < 6; i++)
		begin
			c = 4'($urandom);
			o = 4'($urandom);
			directIn <= c;
			gateOff <= ~c;
			openSense <= o;
			tick(3);
			pc(c, ~|(o & ~c));
			rdx(Sta, st(1'b0, o & ~c, c, ~|(o & ~c)));
			openSense <= 4'h0;
			tick(3);
			rdx(Sta, st(1'b0, o & ~c, c, 1'b1));
			rdx(Sta, st(1'b0, 4'h0, c, 1'b1));
		end
		{directIn, gateOff, openSense} <= 12'h00f;
		tick(3);
		pc(4'h0, 1'b1);
		wrx(Cfg, 32'h5);
		gateOff <= 4'hf;
		tick(3);
		rdx(Sta, st(1'b0, 4'ha, 4'h0, 1'b0));
		openSense <= 4'h0;
		wrx(Cfg, 32'h0);
		rdx(Sta, st(1'b0, 4'ha, 4'h0, 1'b1));
		$display("test open load done");
		{batteryLow, batteryPorLow, batteryDead} <= 3'h7;
		for (int i = 0; i < 16; i++)
		begin
			prev = chainIn;
			chainIn <= 1'($urandom);
			tick(1);
			`CHK("chainOut", prev, chainOut);
		end
		c = 4'($urandom);
		gateOff <= c;
		tick(2);
		rdx(Sen, {24'h0, c, 4'h7});
		tick(2);
		`CHK("queue", 0, expQ.size());
		$display("test chain done");
		report_and_stop();
	end
endmodule
